// >>> src/mmod_pkg.sv
package mmod_pkg;

	// Address map and widths
	localparam int          PM_W          = 24;
	localparam int          DM_W          = 16;
	localparam int          AW            = 14;
	localparam logic [13:0] OVL_BASE      = 14'h2000;
	localparam logic [13:0] PM_ZERO       = 14'h0000;
	localparam int          OVL_BIT       = 13;
	localparam int          BOOT_WORDS    = 32;
	localparam logic [5:0]  BOOT_LAST     = 6'h1F;
	localparam int          MMR_COUNT     = 32;
	localparam logic [13:0] MMR_BASE      = 14'h3FE0;

	// Register map
	localparam logic [3:0]  REG_OVLAY     = 4'h0;
	localparam logic [3:0]  REG_WAIT      = 4'h1;
	localparam logic [3:0]  REG_STATUS    = 4'h2;
	localparam logic [3:0]  REG_FLAG      = 4'h3;

	// Reset values
	localparam logic [1:0]  OVL_RST       = 2'h0;
	localparam logic [2:0]  WAIT_RST      = 3'h7;
	localparam logic        WMODE_RST     = 1'b0;
	localparam int          WAIT_W        = 3;
	localparam int          WSTR_W        = 4;

	typedef enum logic [1:0] {
		MMOD_OVL_INT,
		MMOD_OVL_EXT1,
		MMOD_OVL_EXT2,
		MMOD_OVL_RSVD
	} mmod_ovl_e;

	typedef enum logic [1:0] {
		MMOD_BOOT_NONE,
		MMOD_BOOT_BYTE,
		MMOD_BOOT_HOST
	} mmod_boot_e;

	// Latched strap image
	typedef struct packed {
		logic full_mode;
		logic ack_open_drain;
		mmod_boot_e boot;
		logic low_pm_ext;
	} mmod_strap_s;

	// Memory access request
	typedef struct packed {
		logic        req;
		logic        is_pm;
		logic        wr;
		logic [13:0] addr;
	} mmod_acc_s;

	// Decoded external access
	typedef struct packed {
		logic        ext;
		logic        internal;
		logic [13:0] ext_addr;
	} mmod_dec_s;

endpackage : mmod_pkg

// >>> src/mmod_ovl_dec.sv
`timescale 1ns/1ps
`default_nettype none
// Overlay decode for one memory space
module mmod_ovl_dec (
	input  wire logic                 i_host_mode, // Host memory mode
	input  wire logic                 i_low_ext,   // Low half external (PM)
	input  wire logic [1:0]           i_ovl,       // Overlay select
	input  wire mmod_pkg::mmod_acc_s  i_acc,       // Access request
	output logic                      o_rsvd,      // Reserved select seen
	output mmod_pkg::mmod_dec_s       o_dec        // Decode result
);
	import mmod_pkg::*;

	wire upper   = i_acc.addr[OVL_BIT];
	wire ext_up  = upper && (i_ovl == MMOD_OVL_EXT1 || i_ovl == MMOD_OVL_EXT2);
	wire ext_low = !upper && i_low_ext;
	wire hi_bit  = (i_ovl == MMOD_OVL_EXT2);

	// Host mode has only A0 out, so upper bits are dropped
	wire [13:0] full_a = {hi_bit, i_acc.addr[12:0]};
	wire [13:0] host_a = {13'h0000, i_acc.addr[0]};

	assign o_rsvd           = i_acc.req && upper && (i_ovl == MMOD_OVL_RSVD);
	assign o_dec.ext        = i_acc.req && (ext_up || ext_low);
	assign o_dec.internal   = i_acc.req && !(ext_up || ext_low);
	assign o_dec.ext_addr   = i_host_mode ? host_a : full_a;
endmodule : mmod_ovl_dec
`default_nettype wire

// >>> src/mmod_boot_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Boot image staging memory, registered read
module mmod_boot_mem (
	input  wire logic        i_clk,  // Clock
	input  wire logic        i_we,   // Write enable
	input  wire logic [4:0]  i_wa,   // Write index
	input  wire logic [23:0] i_wd,   // Write word
	input  wire logic [4:0]  i_ra,   // Read index
	output logic      [23:0] o_rd    // Read word, registered
);
	logic [23:0] mem [0:31];

	// No reset: contents only meaningful once loaded
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_wa] <= i_wd;
		end
		o_rd <= mem[i_ra];
	end
endmodule : mmod_boot_mem
`default_nettype wire

// >>> src/mmod_top.sv
// Functional notes
// - Memory mode strap is sampled while reset is held; pin shared with flag two.
// - After reset the shared pin is a normal flag; latched mode never changes.
// - Byte DMA boot loads 32 program words before any execution.
// - Straps 1/1/0: no boot, execute from external zero, full memory mode.
// - Host DMA boot holds execution until program word 0 is written.
// - 000 or 110 selects full mode; C=1,B=0 selects host mode.
// - Host mode with ack strap low: ack pin driven both ways.
// - Host mode with ack strap high: ack pin is open drain, pulled up outside.
// - Full mode program memory is 24 bits with two 8K external overlays.
// - Program upper half: overlay 0 internal, 1/2 external with A13 0/1.
// - Host mode overlays use only A0; no external program execution.
// - Data memory 16 bits, 16K internal with 32 mapped registers, two overlays.
// - Data upper half: overlay 0 internal, 1/2 external with A13 0/1.
// - Internal data accesses take one cycle, no waits.
// - External data accesses stretched by wait count and wait mode bit.
// - On reset release with boot configured and no bus request, boot then run at 0.
`timescale 1ns/1ps
`default_nettype none
module mmod_top (
	input  wire logic                 i_clk,        // 50 MHz clock
	input  wire logic                 i_rst,        // Async reset, high
	// Strap and shared flag pins
	input  wire logic                 i_mode_a,     // Boot source strap
	input  wire logic                 i_mode_b,     // Low PM placement strap
	input  wire logic                 i_mode_d,     // Ack drive strap
	input  wire logic                 i_pf2_in,     // Flag two pin level
	output logic                      o_pf2_out,    // Flag two drive value
	output logic                      o_pf2_oe,     // Flag two enable
	input  wire logic                 i_bus_req,    // External bus request
	// Host acknowledge pin
	input  wire logic                 i_host_ack,   // Ack from host logic
	output logic                      o_ack_out,    // Ack pin value
	output logic                      o_ack_oe,     // Ack pin enable
	// Boot sources
	input  wire logic                 i_byte_memory_dma_vld,   // Byte DMA word valid
	input  wire logic [23:0]          i_byte_memory_dma_word,  // Byte DMA word
	input  wire logic                 i_host_wr,    // Host DMA write
	input  wire logic                 i_host_pm,    // Host write to PM
	input  wire logic [13:0]          i_host_addr,  // Host write address
	// Core access
	input  wire mmod_pkg::mmod_acc_s  i_acc,        // Core memory access
	output logic                      o_run,        // Core may execute
	output logic [13:0]               o_start_pc,   // First fetch address
	output logic                      o_start_ext,  // First fetch external
	output logic                      o_stall,      // Access stall
	output logic                      o_ext_sel,    // External select
	output logic [13:0]               o_ext_addr,   // External address
	output logic                      o_ext_fault,  // Illegal host fetch
	output logic [4:0]                o_boot_ra,    // Boot mem read index
	output logic [23:0]               o_boot_rd,    // Boot mem read word
	// Register port
	input  wire logic [3:0]           i_addr,       // Register index
	input  wire logic [15:0]          i_wdata,      // Write data
	input  wire logic                 i_wr,         // Write strobe
	input  wire logic                 i_rd,         // Read strobe
	output logic [15:0]               o_rdata       // Read data
);
	import mmod_pkg::*;

	// Pin synchronisers for straps, flag and bus request
	logic [3:0] sy1_r;
	logic [3:0] sy2_r;
	logic       breq_s1_r;
	logic       breq_s2_r;
	// No reset here on purpose: the strap latch reads sy2_r
	// while reset is held, so the pins must keep flowing then.
	// A reset to zero would hand the latch zeros at release
	// and every part would boot by byte DMA in full mode.
	// Pins stay stable through reset, so two stages settle
	// well inside the minimum reset length.
	always_ff @(posedge i_clk) begin
		sy1_r     <= {i_pf2_in, i_mode_d, i_mode_b, i_mode_a};
		sy2_r     <= sy1_r;
		breq_s1_r <= i_bus_req;
		breq_s2_r <= breq_s1_r;
	end
	wire s_a = sy2_r[0];
	wire s_b = sy2_r[1];
	wire s_d = sy2_r[2];
	wire s_c = sy2_r[3];

	// Straps sampled under reset: reset is async, so a held reset
	// is observed by a synchronised copy and the latch follows it
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= 1'b1;
		end else begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire in_reset = rst_s2_r;

	// Strap pattern decode
	wire pat_full_boot = !s_c && !s_b && !s_a;
	wire pat_full_none = s_c && s_b && !s_a;
	wire pat_host      = s_c && !s_b;
	mmod_strap_s strap_nxt;
	always_comb begin
		strap_nxt = '0;
		strap_nxt.full_mode      = pat_full_boot || pat_full_none;
		strap_nxt.ack_open_drain = pat_host && s_d;
		strap_nxt.low_pm_ext     = pat_full_none;
		if (pat_host && s_a) begin
			strap_nxt.boot = MMOD_BOOT_HOST;
		end else if (pat_full_none) begin
			strap_nxt.boot = MMOD_BOOT_NONE;
		end else begin
			strap_nxt.boot = MMOD_BOOT_BYTE;
		end
	end

	// Held while reset is seen, frozen afterwards
	mmod_strap_s strap_r;
	logic        bus_req_r;
	always_ff @(posedge i_clk) begin
		if (in_reset) begin
			strap_r   <= strap_nxt;
			bus_req_r <= breq_s2_r;
		end
	end
	wire host_mode = !strap_r.full_mode;

	// Programmable flag two: software owned once out of reset
	logic pf_dir_r;
	logic pf_val_r;
	assign o_pf2_oe  = pf_dir_r && !in_reset;
	assign o_pf2_out = pf_val_r;

	// Ack pin: push-pull or open drain
	assign o_ack_out = strap_r.ack_open_drain ? 1'b0 : i_host_ack;
	assign o_ack_oe  = host_mode && !in_reset &&
		(strap_r.ack_open_drain ? !i_host_ack : 1'b1);

	// Boot sequencing
	typedef enum logic [1:0] {
		MMOD_ST_RESET,
		MMOD_ST_WAIT,
		MMOD_ST_LOAD,
		MMOD_ST_RUN
	} mmod_st_e;
	mmod_st_e   st_r;
	mmod_st_e   st_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;

	wire boot_byte = strap_r.boot == MMOD_BOOT_BYTE;
	wire boot_host = strap_r.boot == MMOD_BOOT_HOST;
	wire pm0_wr    = i_host_wr && i_host_pm && i_host_addr == PM_ZERO;
	wire bword     = i_byte_memory_dma_vld && boot_byte && st_r == MMOD_ST_LOAD;

	// Bus request defers boot until released
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			MMOD_ST_RESET: begin
				if (!in_reset) begin
					st_nxt = MMOD_ST_WAIT;
				end
			end
			MMOD_ST_WAIT: begin
				// Live synchronised request only: a request held
				// at release defers boot, and boot starts once it
				// drops; the latched copy is kept for status only
				if (breq_s2_r) begin
					st_nxt = MMOD_ST_WAIT;
				end else if (strap_r.boot == MMOD_BOOT_NONE) begin
					st_nxt = MMOD_ST_RUN;
				end else begin
					st_nxt = MMOD_ST_LOAD;
				end
			end
			MMOD_ST_LOAD: begin
				if (boot_byte && bword) begin
					cnt_nxt = cnt_r + 6'h01;
					if (cnt_r[4:0] == BOOT_LAST[4:0]) begin
						st_nxt = MMOD_ST_RUN;
					end
				end
				if (boot_host && pm0_wr) begin
					st_nxt = MMOD_ST_RUN;
				end
			end
			MMOD_ST_RUN: st_nxt = MMOD_ST_RUN;
			default: st_nxt = MMOD_ST_RESET;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r  <= MMOD_ST_RESET;
			cnt_r <= 6'h00;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	wire bus_waiting = bus_req_r;

	assign o_run       = st_r == MMOD_ST_RUN;
	assign o_start_pc  = PM_ZERO;
	assign o_start_ext = strap_r.boot == MMOD_BOOT_NONE;

	// Boot words staged for the program memory loader
	mmod_boot_mem u_boot_mem (
		.i_clk (i_clk),
		.i_we  (bword),
		.i_wa  (cnt_r[4:0]),
		.i_wd  (i_byte_memory_dma_word),
		.i_ra  (o_boot_ra),
		.o_rd  (o_boot_rd)
	);
	assign o_boot_ra = i_acc.addr[4:0];

	// Overlay select registers, reserved value tolerated
	logic [1:0] pm_ovl_r;
	logic [1:0] dm_ovl_r;
	logic [2:0] dm_external_wait_count_r;
	logic       wmode_r;
	logic       rsvd_seen_r;

	mmod_acc_s pm_acc;
	mmod_acc_s dm_acc;
	mmod_dec_s pm_dec;
	mmod_dec_s dm_dec;
	wire       pm_rsvd;
	wire       dm_rsvd;
	always_comb begin
		pm_acc     = i_acc;
		pm_acc.req = i_acc.req && i_acc.is_pm;
		dm_acc     = i_acc;
		dm_acc.req = i_acc.req && !i_acc.is_pm;
	end

	mmod_ovl_dec u_pm_dec (
		.i_host_mode (host_mode),
		.i_low_ext   (strap_r.low_pm_ext),
		.i_ovl       (pm_ovl_r),
		.i_acc       (pm_acc),
		.o_rsvd      (pm_rsvd),
		.o_dec       (pm_dec)
	);
	mmod_ovl_dec u_dm_dec (
		.i_host_mode (host_mode),
		.i_low_ext   (1'b0),
		.i_ovl       (dm_ovl_r),
		.i_acc       (dm_acc),
		.o_rsvd      (dm_rsvd),
		.o_dec       (dm_dec)
	);

	// PM external in host mode cannot execute: flag it
	assign o_ext_fault = host_mode && pm_dec.ext && !i_acc.wr;
	assign o_ext_sel   = pm_dec.ext || dm_dec.ext;
	assign o_ext_addr  = pm_dec.ext ? pm_dec.ext_addr : dm_dec.ext_addr;

	// Wait stretch for external data only; mode bit makes it twice the count plus one
	function automatic logic [3:0] wait_len(input logic [2:0] n,
						input logic m);
		wait_len = m ? {n, 1'b1} : {1'b0, n};
	endfunction

	logic [3:0] ws_r;
	wire start_ws = dm_dec.ext && ws_r == 4'h0 &&
		wait_len(dm_external_wait_count_r, wmode_r) != 4'h0;
	assign o_stall = start_ws || ws_r > 4'h1;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ws_r <= 4'h0;
		end else if (start_ws) begin
			ws_r <= wait_len(dm_external_wait_count_r, wmode_r);
		end else if (ws_r != 4'h0) begin
			ws_r <= ws_r - 4'h1;
		end
	end

	// Register writes
	wire wr_ovl  = i_wr && i_addr == REG_OVLAY;
	wire wr_wait = i_wr && i_addr == REG_WAIT;
	wire wr_flag = i_wr && i_addr == REG_FLAG;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pm_ovl_r    <= OVL_RST;
			dm_ovl_r    <= OVL_RST;
			dm_external_wait_count_r     <= WAIT_RST;
			wmode_r     <= WMODE_RST;
			pf_dir_r    <= 1'b0;
			pf_val_r    <= 1'b0;
			rsvd_seen_r <= 1'b0;
		end else begin
			if (wr_ovl) begin
				pm_ovl_r <= i_wdata[1:0];
				dm_ovl_r <= i_wdata[5:4];
			end
			if (wr_wait) begin
				dm_external_wait_count_r <= i_wdata[2:0];
				wmode_r <= i_wdata[15];
			end
			if (wr_flag) begin
				pf_dir_r <= i_wdata[0];
				pf_val_r <= i_wdata[1];
			end
			// Set wins over clear on the same cycle
			if (pm_rsvd || dm_rsvd) begin
				rsvd_seen_r <= 1'b1;
			end else if (wr_ovl && i_wdata[8]) begin
				rsvd_seen_r <= 1'b0;
			end
		end
	end

	// Read mux; unmapped reads return zero
	wire [15:0] rd_mux =
		(i_addr == REG_OVLAY)  ? {7'h00, rsvd_seen_r, 2'h0,
					  dm_ovl_r, 2'h0, pm_ovl_r} :
		(i_addr == REG_WAIT)   ? {wmode_r, 12'h000, dm_external_wait_count_r} :
		(i_addr == REG_STATUS) ? {8'h00, o_run, bus_waiting,
					  strap_r.boot, strap_r.low_pm_ext,
					  strap_r.ack_open_drain, host_mode,
					  strap_r.full_mode} :
		(i_addr == REG_FLAG)   ? {13'h0000, s_c, pf_val_r, pf_dir_r} :
		16'h0000;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end else begin
			o_rdata <= 16'h0000;
		end
	end
endmodule : mmod_top
`default_nettype wire

// >>> verif/mmod_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches strap decode, overlay routing and boot holds at the top ports
module mmod_monitor
	import mmod_pkg::*;
(
	input wire logic        i_clk,       // Clock
	input wire logic        i_rst,       // Async reset
	input wire logic        i_mode_a,    // Boot source strap
	input wire logic        i_mode_b,    // Low PM strap
	input wire logic        i_mode_d,    // Ack drive strap
	input wire logic        i_pf2_in,    // Shared pin level
	input wire logic        o_pf2_oe,    // Flag enable
	input wire logic        i_host_ack,  // Ack request
	input wire logic        o_ack_out,   // Ack value
	input wire logic        o_ack_oe,    // Ack enable
	input wire logic        i_byte_memory_dma_vld,  // Boot word strobe
	input wire logic        i_host_wr,   // Host write
	input wire logic        i_host_pm,   // Host write to PM
	input wire logic [13:0] i_host_addr, // Host address
	input wire mmod_acc_s   i_acc,       // Core access
	input wire logic        o_run,       // Run enable
	input wire logic [13:0] o_start_pc,  // First fetch
	input wire logic        o_start_ext, // First fetch external
	input wire logic        o_stall,     // Stall
	input wire logic        o_ext_sel,   // External select
	input wire logic [13:0] o_ext_addr,  // External address
	input wire logic [3:0]  i_addr,      // Register index
	input wire logic [15:0] i_wdata,     // Register data
	input wire logic        i_wr         // Register write
);
	logic       sa, sb, sc, sd;
	logic [1:0] rc;
	logic [5:0] bcnt;
	logic       pm0;
	logic [1:0] pm_ovl, dm_ovl;
	wire        host = sc & !sb;
	wire        full = !host;
	wire        byte_b = !sa & !(sc & sb);
	wire        up = rc == 2'h3;
	wire        req_dm = i_acc.req & !i_acc.is_pm & i_acc.addr[13];
	wire        req_pm = i_acc.req & i_acc.is_pm & i_acc.addr[13];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Strap image; straps are held steady through reset so a plain sample works
	always_ff @(posedge i_clk)
		if (i_rst) {sd, sc, sb, sa} <= {i_mode_d, i_pf2_in, i_mode_b, i_mode_a};

	// Shadows of release age, boot progress and overlay selects
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{rc, bcnt, pm0, pm_ovl, dm_ovl} <= '0;
		end else begin
			if (!up) rc <= rc + 2'h1;
			if (i_byte_memory_dma_vld && bcnt != 6'h20) bcnt <= bcnt + 6'h01;
			if (i_host_wr && i_host_pm && i_host_addr == 14'h0000) pm0 <= 1'b1;
			if (i_wr && i_addr == 4'h0) {dm_ovl, pm_ovl} <= {i_wdata[5:4], i_wdata[1:0]};
		end
	end

	chk_flag_quiet: assert property (rc < 2'h2 |-> !o_pf2_oe)
		else $error("flag pin driven while straps settle");
	chk_ack_push: assert property (up && host && !sd |->
		o_ack_oe && o_ack_out == i_host_ack) else $error("ack not push-pull");
	chk_ack_drain: assert property (up && host && sd |->
		!o_ack_out && o_ack_oe == !i_host_ack) else $error("ack not open drain");
	chk_ack_full: assert property (up && full |-> !o_ack_oe)
		else $error("ack driven in full mode");
	chk_int_nowait: assert property (i_acc.req && !i_acc.is_pm &&
		(!i_acc.addr[13] || dm_ovl == 2'h0) |-> !o_stall) else $error("internal stall");
	chk_pm_overlay: assert property (full && req_pm && pm_ovl inside {2'h1, 2'h2} |->
		o_ext_sel && o_ext_addr == {pm_ovl == 2'h2, i_acc.addr[12:0]}) else $error("pm overlay");
	chk_dm_overlay: assert property (full && req_dm && dm_ovl inside {2'h1, 2'h2} |->
		o_ext_sel && o_ext_addr == {dm_ovl == 2'h2, i_acc.addr[12:0]}) else $error("dm overlay");
	chk_host_line: assert property (host && req_dm && dm_ovl inside {2'h1, 2'h2} |->
		o_ext_sel && o_ext_addr == {13'h0000, i_acc.addr[0]}) else $error("host overlay");
	chk_byte_hold: assert property (byte_b && bcnt != 6'h20 |-> !o_run)
		else $error("ran before boot words loaded");
	chk_host_hold: assert property (sa && !pm0 |-> !o_run)
		else $error("ran before pm word zero written");
	chk_noboot_go: assert property (!sa && sc && sb && rc == 2'h2 |-> ##[0:8]
		(o_run && o_start_ext && o_start_pc == 14'h0000)) else $error("no-boot start");

	cov_byte_boot: cover property (byte_b && $rose(o_run));
	cov_long_wait: cover property (o_stall [*3]);
	cov_open_drain: cover property (up && host && sd && !o_ack_oe);
endmodule : mmod_monitor

bind mmod_top mmod_monitor mmod_monitor_inst (.i_clk, .i_rst, .i_mode_a, .i_mode_b,
	.i_mode_d, .i_pf2_in, .o_pf2_oe, .i_host_ack, .o_ack_out, .o_ack_oe, .i_byte_memory_dma_vld,
	.i_host_wr, .i_host_pm, .i_host_addr, .i_acc, .o_run, .o_start_pc, .o_start_ext,
	.o_stall, .o_ext_sel, .o_ext_addr, .i_addr, .i_wdata, .i_wr);
`default_nettype wire

// >>> verif/mmod_strap_drv.sv
`timescale 1ns/1ps
`default_nettype none
// Three-state strap driver on the shared flag pin, with a board pull-down
module mmod_strap_drv (
	input  wire logic i_rst,     // Board reset, gates the driver
	input  wire logic i_level,   // Strap level to present
	input  wire logic i_pf2_out, // Device flag value
	input  wire logic i_pf2_oe,  // Device flag enable
	output logic      o_pin      // Resolved pin level
);
	// Driver floats after reset, so the pull-down holds an undriven pin low
	assign o_pin = i_pf2_oe ? i_pf2_out : (i_rst ? i_level : 1'b0);
endmodule : mmod_strap_drv
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mmod_pkg::*;
	logic i_clk, i_rst, i_mode_a, i_mode_b, i_mode_d, i_pf2_in, i_bus_req, i_host_ack;
	logic i_byte_memory_dma_vld, i_host_wr, i_host_pm, i_wr, i_rd, strap_c;
	logic [23:0] i_byte_memory_dma_word, o_boot_rd;
	logic [13:0] i_host_addr, o_start_pc, o_ext_addr, a, ea;
	logic [3:0]  i_addr, p;
	logic [15:0] i_wdata, o_rdata;
	mmod_acc_s   i_acc;
	logic o_pf2_out, o_pf2_oe, o_ack_out, o_ack_oe, o_run, o_start_ext, o_stall;
	logic o_ext_sel, o_ext_fault, hm, sel, pm, m, flt;
	logic [4:0]  o_boot_ra;
	logic [1:0]  s, sp, sq;
	logic [2:0]  n;
	logic [31:0] seed = 32'h0000_516f;
	logic [31:0] rv;
	logic [23:0] bw [32];
	logic [3:0]  pats [6] = '{4'h0, 4'hE, 4'h4, 4'h5, 4'hC, 4'hD};
	int mismatches, checked, k;

	mmod_top mmod_top_inst (.i_clk, .i_rst, .i_mode_a, .i_mode_b, .i_mode_d,
		.i_pf2_in, .o_pf2_out, .o_pf2_oe, .i_bus_req, .i_host_ack, .o_ack_out,
		.o_ack_oe, .i_byte_memory_dma_vld, .i_byte_memory_dma_word, .i_host_wr, .i_host_pm, .i_host_addr,
		.i_acc, .o_run, .o_start_pc, .o_start_ext, .o_stall, .o_ext_sel, .o_ext_addr,
		.o_ext_fault, .o_boot_ra, .o_boot_rd, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
	mmod_strap_drv mmod_strap_drv_inst (.i_rst(i_rst), .i_level(strap_c),
		.i_pf2_out(o_pf2_out), .i_pf2_oe(o_pf2_oe), .o_pin(i_pf2_in));

	// 50 MHz clock
	always #10 i_clk = ~i_clk;

	// Xorshift source, fixed start so runs repeat
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Status image expected for a strap pattern D/C/B/A once running
	function automatic logic [15:0] exp_status(input logic [3:0] q);
		logic h;
		logic [1:0] bt;
		h = q[2] & !q[1];
		bt = q[0] ? 2'h2 : ((q[2] & q[1]) ? 2'h0 : 2'h1);
		return {8'h00, 1'b1, 1'b0, bt, q[1], h & q[3], h, !h};
	endfunction : exp_status

	task automatic end_sim();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic cmp_bit(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: bit got %b want %b", $time, g, e);
		end
	endtask : cmp_bit

	task automatic cmp_val(input logic [23:0] g, input logic [23:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: value got %h want %h", $time, g, e);
		end
	endtask : cmp_val

	task automatic hang(input logic bad);
		if (bad) begin
			mismatches++;
			$display("mismatch at %0t: wait bound used up", $time);
			end_sim();
		end
	endtask : hang

	// Register bus cycles, one-cycle strobes
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1; i_addr <= ad; i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] ad, input logic [15:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1; i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 cmp_val({8'h00, o_rdata}, {8'h00, e});
	endtask : rd

	// Boot sources: one pulse per word
	task automatic pulse(input logic host, input logic hp, input logic [23:0] d);
		@(posedge i_clk);
		if (host) {i_host_wr, i_host_pm, i_host_addr} <= {1'b1, hp, d[13:0]};
		else {i_byte_memory_dma_vld, i_byte_memory_dma_word} <= {1'b1, d};
		@(posedge i_clk);
		{i_host_wr, i_byte_memory_dma_vld} <= 2'b00;
	endtask : pulse

	// Core access held until the stall drops; k returns the stall length
	task automatic do_acc(input logic ip, input logic [13:0] ad);
		@(posedge i_clk);
		i_acc <= '{1'b1, ip, 1'b0, ad};
		#1 sel = o_ext_sel;
		ea = o_ext_addr;
		flt = o_ext_fault;
		for (k = 0; k < 40 && o_stall === 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		hang(k == 40);
		@(posedge i_clk);
		i_acc <= '0;
	endtask : do_acc

	initial begin
		{i_clk, i_rst, i_mode_a, i_mode_b, i_mode_d, i_bus_req} = 6'b01_0000;
		{i_host_ack, i_byte_memory_dma_vld, i_host_wr, i_host_pm, i_wr, i_rd, strap_c} = '0;
		{i_byte_memory_dma_word, i_host_addr, i_addr, i_wdata, i_acc} = '0;
		for (int t = 0; t < 6; t++) begin
			p = pats[t];
			hm = p[2] & !p[1];
			@(posedge i_clk);
			i_rst <= 1'b1;
			{i_mode_d, strap_c, i_mode_b, i_mode_a} <= p;
			repeat (6) @(posedge i_clk);
			i_rst <= 1'b0;
			rd(REG_OVLAY, 16'h0000);
			rd(REG_WAIT, 16'h0007);
			if (p[0]) begin
				pulse(1'b1, 1'b1, 24'h5);
				pulse(1'b1, 1'b0, 24'h0);
				#1 cmp_bit(o_run, 1'b0);
				pulse(1'b1, 1'b1, 24'h0);
			end else if (!(p[2] & p[1])) begin
				for (int w = 0; w < 32; w++) begin
					rv = rnd();
					bw[w] = rv[23:0];
					if (w == 31) #1 cmp_bit(o_run, 1'b0);
					pulse(1'b0, 1'b0, bw[w]);
				end
			end
			for (k = 0; k < 200 && o_run !== 1'b1; k++) @(posedge i_clk);
			hang(k == 200);
			cmp_bit(o_start_ext, p[2] & p[1] & !p[0]);
			if (!p[0] && !(p[2] & p[1])) begin
				do_acc(1'b1, 14'h001F);
				#1 cmp_val(o_boot_rd, bw[31]);
			end
			rd(REG_STATUS, exp_status(p));
			for (int h = 0; h < 2; h++) begin
				@(posedge i_clk);
				i_host_ack <= h[0];
				#1 cmp_bit(o_ack_oe, hm & (!p[3] | !h[0]));
				if (hm) cmp_bit(o_ack_out, !p[3] & h[0]);
			end
			wr(REG_FLAG, 16'h0003);
			repeat (3) @(posedge i_clk);
			rd(REG_FLAG, 16'h0007);
			cmp_bit(o_pf2_oe & o_pf2_out, 1'b1);
			wr(REG_FLAG, 16'h0000);
			repeat (3) @(posedge i_clk);
			rd(REG_FLAG, 16'h0000);
			rd(REG_STATUS, exp_status(p));
			for (int r = 0; r < 10; r++) begin
				rv = rnd();
				sp = rv[1:0] % 2'h3;
				sq = rv[3:2] % 2'h3;
				pm = !hm & rv[4];
				a = (r == 0) ? 14'h2000 : ((r == 1) ? 14'h3FFF : {1'b1, rv[28:16]});
				s = pm ? sp : sq;
				wr(REG_OVLAY, {10'h000, sq, 2'h0, sp});
				do_acc(pm, a);
				cmp_bit(sel, s != 2'h0);
				if (s != 2'h0)
					cmp_val(ea, hm ? {13'h0, a[0]} : {s == 2'h2, a[12:0]});
			end
			wr(REG_OVLAY, 16'h0033);
			do_acc(1'b0, 14'h2345);
			cmp_bit(sel, 1'b0);
			rd(REG_OVLAY, 16'h0133);
			wr(REG_OVLAY, 16'h0100);
			rd(REG_OVLAY, 16'h0000);
			wr(REG_OVLAY, 16'h0001);
			do_acc(1'b1, 14'h2004);
			cmp_bit(flt, hm);
			rv = rnd();
			{m, n} = (t == 0) ? 4'hF : rv[3:0];
			wr(REG_WAIT, {m, 12'h000, n});
			rd(REG_WAIT, {m, 12'h000, n});
			wr(REG_OVLAY, 16'h0010);
			do_acc(1'b0, 14'h2001);
			cmp_val(k[23:0], m ? 2 * n + 1 : n);
			do_acc(1'b0, 14'h0100);
			cmp_val(k[23:0], 24'h0);
			rd(4'h9, 16'h0000);
			$display("test %0d done", t);
		end
		end_sim();
	end
endmodule : testbench
`default_nettype wire
